// >>> hw/ctrl_bank.sv
// Control register bank of the line interface framer
`timescale 1ns/100ps
module ctrl_bank
    import ctrl_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_hit,
    input wire logic terminal_loop_pin,
    input wire logic overhead_program_pin,
    output logic hdr_correct_disable,
    output logic hec_gen_disable,
    output logic terminal_loop_enable,
    output logic facility_loop_output,
    output logic keep_multi_error_cells,
    output logic keep_idle_cells,
    output logic keep_unassigned_cells,
    output logic clock_loop_output,
    output logic filler_unassigned,
    output logic overhead_program_mode,
    output logic alt_data_format,
    output logic force_line_ais,
    output logic force_line_ferf,
    output logic force_path_ferf,
    output logic cell_alignment_loss_soak_enable,
    output logic force_path_ais,
    output logic rx_frame_descramble_bypass,
    output logic rx_cell_descramble_bypass,
    output logic tx_frame_scramble_bypass,
    output logic tx_cell_scramble_bypass,
    output logic short_frame_test,
    output logic counter_test,
    output logic ram_access_test,
    output logic cell_loop_test,
    output logic [1:0] force_path_rdi_code,
    output logic sdh_frames
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cr1;
        logic [7:0] cr2;
        logic [7:0] cr3;
        logic [7:0] cr4;
        logic [7:0] cr5;
        logic [7:0] rdata;
        logic hit;
    } bank_s;

    bank_s state_reg;
    bank_s state_next;

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    logic [7:0] cr1_q;
    logic [7:0] cr2_q;
    logic [7:0] cr3_q;
    logic [7:0] cr4_q;
    logic [7:0] cr5_q;

    assign cr1_q = state_reg.cr1;
    assign cr2_q = state_reg.cr2;
    assign cr3_q = state_reg.cr3;
    assign cr4_q = state_reg.cr4;
    assign cr5_q = state_reg.cr5;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic sel_id;
    logic sel_cr1;
    logic sel_cr2;
    logic sel_cr3;
    logic sel_cr4;
    logic sel_cr5;
    logic sel_bank;

    assign sel_id = (addr == ID_OFFSET);
    assign sel_cr1 = (addr == RX_HDR_DROP_OFFSET);
    assign sel_cr2 = (addr == LOOP_FILLER_ALARM_OFFSET);
    assign sel_cr3 = (addr == SCRAMBLER_TEST_OFFSET);
    assign sel_cr4 = (addr == LOOP_RDI_OFFSET);
    assign sel_cr5 = (addr == FRAME_FORMAT_OFFSET);
    assign sel_bank = sel_cr1 | sel_cr2 | sel_cr3 | sel_cr4 | sel_cr5;

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    logic wr_id;
    logic wr_cr1;
    logic wr_cr2;
    logic wr_cr3;
    logic wr_cr4;
    logic wr_cr5;

    assign wr_id = wr_en & sel_id;
    assign wr_cr1 = wr_en & sel_cr1;
    assign wr_cr2 = wr_en & sel_cr2;
    assign wr_cr3 = wr_en & sel_cr3;
    assign wr_cr4 = wr_en & sel_cr4;
    assign wr_cr5 = wr_en & sel_cr5;

    // ------------------------------------------------------------
    // Clear sources
    // ------------------------------------------------------------
    logic hw_clear;
    logic sw_clear;
    logic clear_all;

    assign hw_clear = ~reset_n;
    assign sw_clear = wr_id;
    assign clear_all = hw_clear | sw_clear;

    // ------------------------------------------------------------
    // Write data per register
    // ------------------------------------------------------------
    logic [7:0] cr1_wdata;
    logic [7:0] cr2_wdata;
    logic [7:0] cr3_wdata;
    logic [7:0] cr4_wdata;
    logic [7:0] cr5_wdata;

    assign cr1_wdata = wr_data & CR1_IMPL_MASK;
    assign cr2_wdata = wr_data;
    assign cr3_wdata = wr_data;
    assign cr4_wdata = wr_data;
    assign cr5_wdata = wr_data;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rd_cr1;
    logic [7:0] rd_cr2;
    logic [7:0] rd_cr3;
    logic [7:0] rd_cr4;
    logic [7:0] rd_cr5;
    logic [7:0] rd_mux;
    logic rd_valid;

    assign rd_cr1 = {8{sel_cr1}} & cr1_q & CR1_IMPL_MASK;
    assign rd_cr2 = {8{sel_cr2}} & cr2_q;
    assign rd_cr3 = {8{sel_cr3}} & cr3_q;
    assign rd_cr4 = {8{sel_cr4}} & cr4_q;
    assign rd_cr5 = {8{sel_cr5}} & cr5_q;
    assign rd_mux = rd_cr1 | rd_cr2 | rd_cr3 | rd_cr4 | rd_cr5;
    assign rd_valid = rd_en & sel_bank;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.hit = 1'b0;
        if (clear_all) begin
            state_next.cr1 = CTRL_RESET;
            state_next.cr2 = CTRL_RESET;
            state_next.cr3 = CTRL_RESET;
            state_next.cr4 = CTRL_RESET;
            state_next.cr5 = CTRL_RESET;
        end else begin
            if (wr_cr1) begin
                state_next.cr1 = cr1_wdata;
            end
            if (wr_cr2) begin
                state_next.cr2 = cr2_wdata;
            end
            if (wr_cr3) begin
                state_next.cr3 = cr3_wdata;
            end
            if (wr_cr4) begin
                state_next.cr4 = cr4_wdata;
            end
            if (wr_cr5) begin
                state_next.cr5 = cr5_wdata;
            end
        end
        if (rd_en) begin
            state_next.rdata = rd_mux;
            state_next.hit = rd_valid;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign rd_data = state_reg.rdata;
    assign rd_hit = state_reg.hit;

    // ------------------------------------------------------------
    // Register 1 controls
    // ------------------------------------------------------------
    logic hdr_corr_off;
    logic hec_gen_off;
    logic term_loop_set;
    logic fac_loop_set;
    logic keep_multi_set;
    logic keep_idle_set;
    logic keep_unassigned_set;
    logic term_loop_merged;

    assign hdr_corr_off = cr1_q[HDR_CORR_OFF_BIT];
    assign hec_gen_off = cr1_q[HEC_GEN_OFF_BIT];
    assign term_loop_set = cr1_q[TERM_LOOP_BIT];
    assign fac_loop_set = cr1_q[FAC_LOOP_BIT];
    assign keep_multi_set = cr1_q[KEEP_MULTI_ERR_BIT];
    assign keep_idle_set = cr1_q[KEEP_IDLE_BIT];
    assign keep_unassigned_set = cr1_q[KEEP_UNASSIGNED_BIT];
    assign term_loop_merged = term_loop_set | terminal_loop_pin;

    assign hdr_correct_disable = hdr_corr_off;
    assign hec_gen_disable = hec_gen_off;
    assign terminal_loop_enable = term_loop_merged;
    assign facility_loop_output = fac_loop_set;
    assign keep_multi_error_cells = keep_multi_set;
    assign keep_idle_cells = keep_idle_set;
    assign keep_unassigned_cells = keep_unassigned_set;

    // ------------------------------------------------------------
    // Register 2 controls
    // ------------------------------------------------------------
    logic clock_loop_set;
    logic filler_unassigned_set;
    logic oh_program_set;
    logic alt_format_set;
    logic line_ais_set;
    logic line_ferf_set;
    logic path_ferf_set;
    logic soak_set;
    logic oh_program_merged;

    assign clock_loop_set = cr2_q[CLOCK_LOOP_BIT];
    assign filler_unassigned_set = cr2_q[FILLER_UNASSIGNED_BIT];
    assign oh_program_set = cr2_q[OH_PROGRAM_BIT];
    assign alt_format_set = cr2_q[ALT_FORMAT_BIT];
    assign line_ais_set = cr2_q[FORCE_LINE_AIS_BIT];
    assign line_ferf_set = cr2_q[FORCE_LINE_FERF_BIT];
    assign path_ferf_set = cr2_q[FORCE_PATH_FERF_BIT];
    assign soak_set = cr2_q[SOAK_ENABLE_BIT];
    assign oh_program_merged = oh_program_set | overhead_program_pin;

    assign clock_loop_output = clock_loop_set;
    assign filler_unassigned = filler_unassigned_set;
    assign overhead_program_mode = oh_program_merged;
    assign alt_data_format = alt_format_set;
    assign force_line_ais = line_ais_set;
    assign force_line_ferf = line_ferf_set;
    assign force_path_ferf = path_ferf_set;
    assign cell_alignment_loss_soak_enable = soak_set;

    // ------------------------------------------------------------
    // Register 3 controls
    // ------------------------------------------------------------
    logic path_ais_set;
    logic rx_frame_descr_off;
    logic rx_cell_descr_off;
    logic tx_frame_scr_off;
    logic tx_cell_scr_off;
    logic short_frame_set;
    logic counter_test_set;
    logic ram_test_set;

    assign path_ais_set = cr3_q[FORCE_PATH_AIS_BIT];
    assign rx_frame_descr_off = cr3_q[RX_FRAME_DESCR_OFF_BIT];
    assign rx_cell_descr_off = cr3_q[RX_CELL_DESCR_OFF_BIT];
    assign tx_frame_scr_off = cr3_q[TX_FRAME_SCR_OFF_BIT];
    assign tx_cell_scr_off = cr3_q[TX_CELL_SCR_OFF_BIT];
    assign short_frame_set = cr3_q[SHORT_FRAME_TEST_BIT];
    assign counter_test_set = cr3_q[COUNTER_TEST_BIT];
    assign ram_test_set = cr3_q[RAM_TEST_BIT];

    assign force_path_ais = path_ais_set;
    assign rx_frame_descramble_bypass = rx_frame_descr_off;
    assign rx_cell_descramble_bypass = rx_cell_descr_off;
    assign tx_frame_scramble_bypass = tx_frame_scr_off;
    assign tx_cell_scramble_bypass = tx_cell_scr_off;
    assign short_frame_test = short_frame_set;
    assign counter_test = counter_test_set;
    assign ram_access_test = ram_test_set;

    // ------------------------------------------------------------
    // Register 4 controls
    // ------------------------------------------------------------
    logic cell_loop_set;
    logic rdi_01_set;
    logic rdi_10_set;
    logic rdi_11_set;

    assign cell_loop_set = cr4_q[CELL_LOOP_TEST_BIT];
    assign rdi_01_set = cr4_q[FORCE_RDI_01_BIT];
    assign rdi_10_set = cr4_q[FORCE_RDI_10_BIT];
    assign rdi_11_set = cr4_q[FORCE_RDI_11_BIT];

    assign cell_loop_test = cell_loop_set;
    // Code 01, 10, or 11 from the three force bits, ORed
    assign force_path_rdi_code[0] = rdi_01_set | rdi_11_set;
    assign force_path_rdi_code[1] = rdi_10_set | rdi_11_set;

    // ------------------------------------------------------------
    // Register 5 controls
    // ------------------------------------------------------------
    logic sdh_set;

    assign sdh_set = cr5_q[SDH_FRAMES_BIT];
    assign sdh_frames = sdh_set;

endmodule

// >>> hw/ctrl_bank_pkg.sv
// Package with control register offsets, bit positions and reset values
package ctrl_bank_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] ID_OFFSET = 12'h000;
    localparam logic [11:0] RX_HDR_DROP_OFFSET = 12'h007;
    localparam logic [11:0] LOOP_FILLER_ALARM_OFFSET = 12'h008;
    localparam logic [11:0] SCRAMBLER_TEST_OFFSET = 12'h009;
    localparam logic [11:0] LOOP_RDI_OFFSET = 12'h00a;
    localparam logic [11:0] FRAME_FORMAT_OFFSET = 12'h00b;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CR1_IMPL_MASK = 8'h7f;
    // Register 1 bits
    localparam int HDR_CORR_OFF_BIT = 0;
    localparam int HEC_GEN_OFF_BIT = 1;
    localparam int TERM_LOOP_BIT = 2;
    localparam int FAC_LOOP_BIT = 3;
    localparam int KEEP_MULTI_ERR_BIT = 4;
    localparam int KEEP_IDLE_BIT = 5;
    localparam int KEEP_UNASSIGNED_BIT = 6;
    // Register 2 bits
    localparam int CLOCK_LOOP_BIT = 0;
    localparam int FILLER_UNASSIGNED_BIT = 1;
    localparam int OH_PROGRAM_BIT = 2;
    localparam int ALT_FORMAT_BIT = 3;
    localparam int FORCE_LINE_AIS_BIT = 4;
    localparam int FORCE_LINE_FERF_BIT = 5;
    localparam int FORCE_PATH_FERF_BIT = 6;
    localparam int SOAK_ENABLE_BIT = 7;
    // Register 3 bits
    localparam int FORCE_PATH_AIS_BIT = 0;
    localparam int RX_FRAME_DESCR_OFF_BIT = 1;
    localparam int RX_CELL_DESCR_OFF_BIT = 2;
    localparam int TX_FRAME_SCR_OFF_BIT = 3;
    localparam int TX_CELL_SCR_OFF_BIT = 4;
    localparam int SHORT_FRAME_TEST_BIT = 5;
    localparam int COUNTER_TEST_BIT = 6;
    localparam int RAM_TEST_BIT = 7;
    // Register 4 bits
    localparam int CELL_LOOP_TEST_BIT = 0;
    localparam int FORCE_RDI_01_BIT = 1;
    localparam int FORCE_RDI_10_BIT = 2;
    localparam int FORCE_RDI_11_BIT = 3;
    // Register 5 bits
    localparam int SDH_FRAMES_BIT = 0;
endpackage

// >>> testbench/ctrl_bank_asserts.sv
// Assertions for the control register bank
`timescale 1ns/100ps
module ctrl_bank_asserts
    import ctrl_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_hit,
    input wire logic facility_loop_output,
    input wire logic overhead_program_pin,
    input wire logic overhead_program_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr7;
        clk_en && reset_n && wr_en && addr == 12'h007;
    endsequence
    sequence s_rd7;
        clk_en && reset_n && rd_en && !wr_en && addr == 12'h007;
    endsequence
    property p_dec; clk_en && reset_n && rd_en |=> rd_hit == ($past(addr) inside {[12'h007:12'h00b]}); endproperty
    a_dec: assert property (p_dec) else $error("read hit wrong");
    property p_hw; clk_en && !reset_n |=> !facility_loop_output; endproperty
    a_hw: assert property (p_hw) else $error("hardware clear missed");
    property p_id; clk_en && reset_n && wr_en && addr == ID_OFFSET |=> !facility_loop_output; endproperty
    a_id: assert property (p_id) else $error("software clear missed");
    property p_fac; s_wr7 |=> facility_loop_output == $past(wr_data[3]); endproperty
    a_fac: assert property (p_fac) else $error("facility loop level wrong");
    property p_hold; !(clk_en && (wr_en || !reset_n)) |=> $stable(facility_loop_output); endproperty
    a_hold: assert property (p_hold) else $error("control level moved");
    property p_or; overhead_program_pin |-> overhead_program_mode; endproperty
    a_or: assert property (p_or) else $error("program pin not merged");
    property p_b7; s_rd7 |=> rd_data[7] == 1'h0; endproperty
    a_b7: assert property (p_b7) else $error("unused bit reads one");
    property p_rb; s_wr7 ##1 s_rd7 |=> rd_data == ($past(wr_data, 2) & 8'h7f); endproperty
    a_rb: assert property (p_rb) else $error("read back wrong");
endmodule
bind ctrl_bank ctrl_bank_asserts u_chk (.clk(clk), .rst(rst), .reset_n(reset_n), .clk_en(clk_en), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_hit(rd_hit),
    .facility_loop_output(facility_loop_output), .overhead_program_pin(overhead_program_pin),
    .overhead_program_mode(overhead_program_mode));

// >>> testbench/ctrl_bank_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t %h %h", $time, g, e); end end
module ctrl_bank_test;
    import ctrl_bank_pkg::*;
    logic clk = 1'h0, rst = 1'h1, reset_n = 1'h1, clk_en = 1'h1, wr_en = 1'h0, rd_en = 1'h0, rd_hit;
    logic terminal_loop_pin = 1'h0, overhead_program_pin = 1'h0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic [7:0] r [5];
    logic hdr_correct_disable, hec_gen_disable, terminal_loop_enable, facility_loop_output, keep_multi_error_cells;
    logic keep_idle_cells, keep_unassigned_cells, clock_loop_output, filler_unassigned, overhead_program_mode;
    logic alt_data_format, force_line_ais, force_line_ferf, force_path_ferf, cell_alignment_loss_soak_enable;
    logic force_path_ais, rx_frame_descramble_bypass, rx_cell_descramble_bypass, tx_frame_scramble_bypass;
    logic tx_cell_scramble_bypass, short_frame_test, counter_test, ram_access_test, cell_loop_test, sdh_frames;
    logic [1:0] force_path_rdi_code;
    int err_count = 0;
    int n_checks = 0;
    wire logic [26:0] got = {keep_unassigned_cells, keep_idle_cells, keep_multi_error_cells, facility_loop_output,
        terminal_loop_enable, hec_gen_disable, hdr_correct_disable, cell_alignment_loss_soak_enable, force_path_ferf,
        force_line_ferf, force_line_ais, alt_data_format, overhead_program_mode, filler_unassigned, clock_loop_output,
        ram_access_test, counter_test, short_frame_test, tx_cell_scramble_bypass, tx_frame_scramble_bypass,
        rx_cell_descramble_bypass, rx_frame_descramble_bypass, force_path_ais, force_path_rdi_code, cell_loop_test,
        sdh_frames};
    always #20 clk = ~clk;
    ctrl_bank u_ctrl_bank (.*);
    // Expected control levels from the model
    function automatic logic [26:0] exp_out();
        return {r[0][6:3], r[0][2] | terminal_loop_pin, r[0][1:0], r[1][7:3], r[1][2] | overhead_program_pin,
            r[1][1:0], r[2], r[3][2] | r[3][3], r[3][1] | r[3][3], r[3][0], r[4][0]};
    endfunction
    // One access per clock, strobes left up for back to back use
    task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic w);
        logic hit;
        logic [7:0] e;
        logic [26:0] x;
        hit = a inside {[12'h007:12'h00b]};
        e = hit ? r[a - 12'h007] : 8'h00;
        addr = a;
        wr_data = d;
        wr_en = w;
        rd_en = !w;
        @(negedge clk);
        if (clk_en && reset_n && !w)
            `CHK({rd_hit, rd_data}, {hit, e})
        if (clk_en && w && hit)
            r[a - 12'h007] = (a == 12'h007) ? (d & 8'h7f) : d;
        if (clk_en && ((w && a == ID_OFFSET) || !reset_n))
            r = '{default: 8'h00};
        x = exp_out();
        `CHK(got[26:15], x[26:15])
        `CHK(got[26:15], x[26:15])
        `CHK(got[14:0], x[14:0])
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(32'he1a16981));
        r = '{default: 8'h00};
        repeat (10) @(negedge clk);
        rst = 1'h0;
        acc(12'h007, 8'hff, 1'h1);
        acc(12'h007, 8'h00, 1'h0);
        for (int i = 7; i < 12; i++) begin
            acc(12'(i), 8'hff, 1'h1);
            acc(12'(i), 8'h00, 1'h0);
        end
        acc(12'h00c, 8'h00, 1'h0);
        acc(ID_OFFSET, 8'h5a, 1'h1);
        $display("Test directed done");
        for (int i = 0; i < 400; i++) begin
            logic [11:0] a;
            logic [7:0] d;
            clk_en = ($urandom_range(7) != 0);
            reset_n = ($urandom_range(31) != 0);
            terminal_loop_pin = 1'($urandom_range(1));
            overhead_program_pin = 1'($urandom_range(1));
            a = 12'($urandom_range(15));
            d = 8'($urandom);
            if (a == SCRAMBLER_TEST_OFFSET)
                d[7:5] = 3'h0;
            if (a == LOOP_RDI_OFFSET)
                d[0] = 1'h0;
            acc(a, d, 1'($urandom));
        end
        $display("Test random done");
        stop_test();
    end
endmodule
